// ==== rotate_right_subtract_borrow_alu.sv ====
`timescale 1ns/10ps

// How it works
// - A plain right rotate to memory moves every bit one place down, wraps bit 0 into bit 7, writes memory, and touches no flag.
// - The plain right rotate to the working register gives the same wrapped result in the working register, leaving memory and flags alone.
// - The right rotate through carry to memory rotates a nine-bit ring: old carry enters bit 7 and old bit 0 becomes the new carry, result to memory.
// - The right rotate through carry to the working register does the same ring rotation, loads the working register, updates carry and leaves memory.
// - Subtract with borrow computes working register minus memory operand, minus one more when carry is 0.
// - The register form writes the difference to the working register; the memory form writes it to memory and keeps the working register.
// - After a subtract with borrow, carry is 0 when a borrow occurred and 1 when the true result is zero or positive.
// - Subtract with borrow updates all six status flags, while the through-carry rotates change only carry.
module rotate_right_subtract_borrow_alu (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // operation request
    input wire logic op_valid_i,
    input wire logic [rrsb_alu_pkg::OP_W-1:0] op_code_i,
    input wire logic [rrsb_alu_pkg::DATA_W-1:0] mem_operand_i,
    // side loads from the rest of the core
    input wire logic wreg_load_i,
    input wire logic [rrsb_alu_pkg::DATA_W-1:0] wreg_load_data_i,
    input wire logic flags_load_i,
    input wire logic [rrsb_alu_pkg::FLAG_W-1:0] flags_load_data_i,
    // memory write-back
    output logic mem_wr_en_o,
    output logic [rrsb_alu_pkg::DATA_W-1:0] mem_wr_data_o,
    // architectural state
    output logic [rrsb_alu_pkg::DATA_W-1:0] working_register_o,
    output logic carry_flag_o,
    output logic zero_flag_o,
    output logic half_byte_borrow_flag_o,
    output logic sign_wrap_flag_o,
    output logic signed_chain_flag_o,
    output logic chained_null_flag_o,
    // completion
    output logic op_done_o,
    output logic op_illegal_o
);
    import rrsb_alu_pkg::*;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------

    // true when the result goes to data memory
    function automatic logic to_memory(input logic [2:0] code);
        to_memory = (code == rotate_mem_right) || (code == rotate_mem_right_thru_borrow_bit) ||
                    (code == subtract_borrow_to_mem);
    endfunction : to_memory

    // true when the code is one this slice executes
    function automatic logic is_legal(input logic [2:0] code);
        is_legal = (code <= OP_LAST);
    endfunction : is_legal

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] wreg;
    logic [5:0] flags;
    logic [7:0] mem_data;
    logic mem_we;
    logic done;
    logic illegal;

    logic [7:0] next_wreg;
    logic [5:0] next_flags;
    logic [7:0] next_mem_data;

    // ------------------------------------------------------------
    // operation decode
    // ------------------------------------------------------------
    logic op_ok;
    logic op_bad;
    logic dest_mem;
    logic is_rot_plain;
    logic is_rot_carry;
    logic is_sub;

    assign op_ok = op_valid_i & is_legal(op_code_i);
    assign op_bad = op_valid_i & ~is_legal(op_code_i);
    assign dest_mem = to_memory(op_code_i);
    assign is_rot_plain = (op_code_i == rotate_mem_right) || (op_code_i == rotate_right_to_wreg);
    assign is_rot_carry = (op_code_i == rotate_mem_right_thru_borrow_bit) ||
                          (op_code_i == rotate_right_thru_borrow_bit_to_wreg);
    assign is_sub = (op_code_i == subtract_borrow_to_wreg) || (op_code_i == subtract_borrow_to_mem);

    // ------------------------------------------------------------
    // rotate datapath
    // ------------------------------------------------------------
    logic [7:0] rot_plain;
    logic [7:0] rot_carry;
    logic old_carry;

    assign old_carry = flags[FLAG_CARRY_POS];

    // bits 0..6 take the bit above them in both rotate forms
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_shift
            assign rot_plain[gi] = mem_operand_i[gi+1];
            assign rot_carry[gi] = mem_operand_i[gi+1];
        end
    endgenerate

    // top bit: wrapped bit 0, or the old carry
    assign rot_plain[7] = mem_operand_i[0];
    assign rot_carry[7] = old_carry;

    // ------------------------------------------------------------
    // subtract datapath
    // ------------------------------------------------------------
    logic [7:0] sub_diff;
    logic sub_carry;
    logic sub_zero;
    logic sub_half;
    logic sub_wrap;
    logic sub_schain;
    logic sub_cnull;

    sub_borrow_unit u_sub (
        .minuend_i(wreg),
        .subtrahend_i(mem_operand_i),
        .carry_in_i(old_carry),
        .chained_null_in_i(flags[FLAG_CNULL_POS]),
        .diff_o(sub_diff),
        .carry_o(sub_carry),
        .zero_o(sub_zero),
        .half_byte_borrow_flag_o(sub_half),
        .sign_wrap_flag_o(sub_wrap),
        .signed_chain_flag_o(sub_schain),
        .chained_null_flag_o(sub_cnull)
    );

    // ------------------------------------------------------------
    // result selection
    // ------------------------------------------------------------
    logic [7:0] result;
    logic [5:0] sub_flags;
    logic [5:0] rot_flags;

    assign result = is_rot_plain ? rot_plain : (is_rot_carry ? rot_carry : sub_diff);

    // full flag set from the subtractor
    assign sub_flags = {sub_cnull, sub_schain, sub_wrap, sub_half, sub_zero, sub_carry};

    // through-carry rotates replace only carry with old bit 0
    assign rot_flags = {flags[5:1], mem_operand_i[0]};

    // working register: written by register-destination forms, or by a side load when no request is present
    assign next_wreg = (op_ok && !dest_mem) ? result :
                       (op_valid_i ? wreg : (wreg_load_i ? wreg_load_data_i : wreg)); // loads ignored under any request

    // flags: plain rotates keep all, carry rotates change carry, subtracts change six
    assign next_flags = (op_ok && is_sub) ? sub_flags :
                        (op_ok && is_rot_carry) ? rot_flags :
                        (op_valid_i ? flags : (flags_load_i ? flags_load_data_i : flags));

    // memory data is only updated by memory-destination forms
    assign next_mem_data = (op_ok && dest_mem) ? result : mem_data;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            wreg <= WREG_RESET;
            flags <= FLAGS_RESET;
            mem_data <= MEM_DATA_RESET;
        end else begin
            wreg <= next_wreg;
            flags <= next_flags;
            mem_data <= next_mem_data;
        end
    end

    // write strobe and completion pulses
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mem_we <= 1'b0;
            done <= 1'b0;
            illegal <= 1'b0;
        end else begin
            mem_we <= op_ok & dest_mem;
            done <= op_ok;
            illegal <= op_bad;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign mem_wr_en_o = mem_we;
    assign mem_wr_data_o = mem_data;
    assign working_register_o = wreg;
    assign carry_flag_o = flags[FLAG_CARRY_POS];
    assign zero_flag_o = flags[FLAG_ZERO_POS];
    assign half_byte_borrow_flag_o = flags[FLAG_HALF_POS];
    assign sign_wrap_flag_o = flags[FLAG_WRAP_POS];
    assign signed_chain_flag_o = flags[FLAG_SCHAIN_POS];
    assign chained_null_flag_o = flags[FLAG_CNULL_POS];
    assign op_done_o = done;
    assign op_illegal_o = illegal;

endmodule : rotate_right_subtract_borrow_alu

// ==== rotate_right_subtract_borrow_alu_bench.sv ====
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end

module rotate_right_subtract_borrow_alu_bench;
    import rrsb_alu_pkg::*;
    logic core_clk_i = 1'b0, rst_n_i = 1'b0, op_valid_i = 1'b0, wreg_load_i = 1'b0, flags_load_i = 1'b0;
    logic [2:0] op_code_i = 3'h0;
    logic [7:0] mem_operand_i = 8'h00, wreg_load_data_i = 8'h00, md = 8'h00, w = 8'h00;
    logic [5:0] flags_load_data_i = 6'h00, f = 6'h00;
    logic mem_wr_en_o, carry_flag_o, zero_flag_o, half_byte_borrow_flag_o, sign_wrap_flag_o;
    logic signed_chain_flag_o, chained_null_flag_o, op_done_o, op_illegal_o;
    logic [7:0] mem_wr_data_o, working_register_o;
    logic [23:0] exp_q[$];
    logic [23:0] note;
    int n_errors = 0;
    int checked = 0;
    wire [23:0] got = {op_illegal_o, mem_wr_en_o, mem_wr_data_o, working_register_o, chained_null_flag_o,
                       signed_chain_flag_o, sign_wrap_flag_o, half_byte_borrow_flag_o, zero_flag_o, carry_flag_o};

    always #12.5 core_clk_i = ~core_clk_i;

    rotate_right_subtract_borrow_alu dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i),
        .op_code_i(op_code_i), .mem_operand_i(mem_operand_i), .wreg_load_i(wreg_load_i),
        .wreg_load_data_i(wreg_load_data_i), .flags_load_i(flags_load_i), .flags_load_data_i(flags_load_data_i),
        .mem_wr_en_o(mem_wr_en_o), .mem_wr_data_o(mem_wr_data_o), .working_register_o(working_register_o),
        .carry_flag_o(carry_flag_o), .zero_flag_o(zero_flag_o), .half_byte_borrow_flag_o(half_byte_borrow_flag_o),
        .sign_wrap_flag_o(sign_wrap_flag_o), .signed_chain_flag_o(signed_chain_flag_o),
        .chained_null_flag_o(chained_null_flag_o), .op_done_o(op_done_o), .op_illegal_o(op_illegal_o));

    // ------------------------------------------------------------
    // drivers: model the op, note the result, present the request
    // ------------------------------------------------------------
    task do_op(input logic [2:0] c, input logic [7:0] m);
        logic [8:0] d;
        logic [4:0] h;
        logic ov, en;
        begin
            en = 1'b0;
            d = {1'b1, w} - {1'b0, m} - {8'h00, ~f[0]};
            h = {1'b1, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~f[0]};
            ov = (w[7] ^ m[7]) & (d[7] ^ w[7]);
            case (c)
                3'h0, 3'h2: begin
                    md = {(c[1] ? f[0] : m[0]), m[7:1]};
                    en = 1'b1;
                end
                3'h1, 3'h3: w = {(c[1] ? f[0] : m[0]), m[7:1]};
                3'h4, 3'h5: begin
                    f = {f[5] & (d[7:0] == 8'h00), d[7] ^ ov, ov, h[4], d[7:0] == 8'h00, d[8]};
                    if (c[0]) begin
                        md = d[7:0];
                        en = 1'b1;
                    end else begin
                        w = d[7:0];
                    end
                end
                default: ;
            endcase
            if (c == 3'h2 || c == 3'h3) f[0] = m[0];
            exp_q.push_back({c > 3'h5, en, md, w, f});
            @(posedge core_clk_i);
            op_valid_i <= 1'b1;
            op_code_i <= c;
            mem_operand_i <= m;
            // side loads are ignored while a request is present
            wreg_load_i <= 1'($urandom);
            wreg_load_data_i <= 8'($urandom);
            flags_load_i <= 1'($urandom);
            flags_load_data_i <= 6'($urandom);
        end
    endtask : do_op

    task load(input logic [7:0] wv, input logic [5:0] fv);
        @(posedge core_clk_i);
        op_valid_i <= 1'b0;
        wreg_load_i <= 1'b1;
        wreg_load_data_i <= wv;
        flags_load_i <= 1'b1;
        flags_load_data_i <= fv;
        w = wv;
        f = fv;
    endtask : load

    task final_report;
        if (n_errors == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : final_report

    // monitor: compare each result against the oldest note
    always @(posedge core_clk_i) begin
        if (op_done_o === 1'b1 || op_illegal_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("[ERR] %0t unexpected result", $time);
            end else begin
                // take the note once so a mismatch print cannot pop a second one
                note = exp_q.pop_front();
                `CHK(got, note)
            end
        end
    end

    // main sequence: borrow boundaries, chained zero, then random ops
    initial begin
        void'($urandom(32'h9022));
        repeat (5) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        load(8'h00, 6'h20);
        do_op(3'h4, 8'h00);
        do_op(3'h2, 8'h01);
        do_op(3'h3, 8'h80);
        load(8'h80, 6'h21);
        do_op(3'h5, 8'h01);
        load(8'h10, 6'h21);
        do_op(3'h5, 8'h10);
        do_op(3'h4, 8'h10);
        for (int i = 0; i < 300; i++) begin
            if (i % 7 == 0) load(8'($urandom), 6'($urandom));
            do_op(3'($urandom), 8'($urandom));
        end
        load(w, f);
        repeat (3) @(posedge core_clk_i);
        `CHK(exp_q.size(), 0)
        final_report();
    end

    // watchdog against a hang
    initial begin
        repeat (3000) @(posedge core_clk_i);
        n_errors++;
        $display("[ERR] %0t timeout", $time);
        final_report();
    end
endmodule : rotate_right_subtract_borrow_alu_bench

// ==== rrsb_alu_checker.sv ====
`timescale 1ns/10ps

module rrsb_alu_checker (
    // clock, reset and request
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic op_valid_i,
    input wire logic [2:0] op_code_i,
    input wire logic [7:0] mem_operand_i,
    // results
    input wire logic mem_wr_en_o,
    input wire logic [7:0] mem_wr_data_o,
    input wire logic [7:0] working_register_o,
    input wire logic carry_flag_o,
    input wire logic zero_flag_o,
    input wire logic half_byte_borrow_flag_o,
    input wire logic sign_wrap_flag_o,
    input wire logic signed_chain_flag_o,
    input wire logic chained_null_flag_o,
    input wire logic op_done_o,
    input wire logic op_illegal_o
);
    import rrsb_alu_pkg::*;
    // ------------------------------------------------------------
    // expected results from the state before the op
    // ------------------------------------------------------------
    logic [8:0] diff9;
    logic [4:0] half5;
    logic [7:0] rot;
    logic [7:0] rotc;
    logic [5:0] flg;
    logic ovf;
    logic sgn;
    logic zr;
    assign diff9 = {1'b1, working_register_o} - {1'b0, mem_operand_i} - {8'h00, ~carry_flag_o};
    assign half5 = {1'b1, working_register_o[3:0]} - {1'b0, mem_operand_i[3:0]} - {4'h0, ~carry_flag_o};
    assign ovf = (working_register_o[7] ^ mem_operand_i[7]) & (diff9[7] ^ working_register_o[7]);
    assign sgn = diff9[7] ^ ovf;
    assign zr = (diff9[7:0] == 8'h00);
    assign rot = {mem_operand_i[0], mem_operand_i[7:1]};
    assign rotc = {carry_flag_o, mem_operand_i[7:1]};
    assign flg = {chained_null_flag_o, signed_chain_flag_o, sign_wrap_flag_o,
                  half_byte_borrow_flag_o, zero_flag_o, carry_flag_o};

    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    property p_rot_mem;
        op_valid_i && op_code_i == 3'h0 |=> mem_wr_en_o && mem_wr_data_o == $past(rot) && $stable(flg);
    endproperty
    a_rot_mem: assert property (p_rot_mem)
        else $error("plain rotate to memory wrong");
    property p_rot_wreg;
        op_valid_i && op_code_i == 3'h1 |=> !mem_wr_en_o && working_register_o == $past(rot) && $stable(flg);
    endproperty
    a_rot_wreg: assert property (p_rot_wreg)
        else $error("plain rotate to register wrong");
    property p_rotc_mem;
        op_valid_i && op_code_i == 3'h2 |=> mem_wr_en_o && mem_wr_data_o == $past(rotc)
            && carry_flag_o == $past(mem_operand_i[0]) && $stable(flg[5:1]);
    endproperty
    a_rotc_mem: assert property (p_rotc_mem)
        else $error("carry rotate to memory wrong");
    property p_rotc_wreg;
        op_valid_i && op_code_i == 3'h3 |=> !mem_wr_en_o && working_register_o == $past(rotc)
            && carry_flag_o == $past(mem_operand_i[0]) && $stable(flg[5:1]);
    endproperty
    a_rotc_wreg: assert property (p_rotc_wreg)
        else $error("carry rotate to register wrong");
    property p_sub_wreg;
        op_valid_i && op_code_i == 3'h4 |=> !mem_wr_en_o && {carry_flag_o, working_register_o} == $past(diff9);
    endproperty
    a_sub_wreg: assert property (p_sub_wreg)
        else $error("subtract to register wrong");
    property p_sub_mem;
        op_valid_i && op_code_i == 3'h5 |=> mem_wr_en_o && {carry_flag_o, mem_wr_data_o} == $past(diff9)
            && $stable(working_register_o);
    endproperty
    a_sub_mem: assert property (p_sub_mem)
        else $error("subtract to memory wrong");
    property p_sub_flags;
        op_valid_i && (op_code_i == 3'h4 || op_code_i == 3'h5) |=> zero_flag_o == $past(zr)
            && half_byte_borrow_flag_o == $past(half5[4]) && sign_wrap_flag_o == $past(ovf)
            && signed_chain_flag_o == $past(sgn) && chained_null_flag_o == ($past(chained_null_flag_o) && zero_flag_o);
    endproperty
    a_sub_flags: assert property (p_sub_flags)
        else $error("subtract flags wrong");
    property p_illegal;
        op_valid_i && op_code_i > 3'h5 |=> op_illegal_o && !op_done_o && !mem_wr_en_o
            && $stable(working_register_o) && $stable(flg);
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("illegal op changed state");
    property p_done;
        op_valid_i && op_code_i <= 3'h5 |=> op_done_o && !op_illegal_o;
    endproperty
    a_done: assert property (p_done)
        else $error("legal op gave no completion pulse");
endmodule : rrsb_alu_checker

bind rotate_right_subtract_borrow_alu rrsb_alu_checker u_chk (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_code_i(op_code_i),
    .mem_operand_i(mem_operand_i), .mem_wr_en_o(mem_wr_en_o), .mem_wr_data_o(mem_wr_data_o),
    .working_register_o(working_register_o), .carry_flag_o(carry_flag_o), .zero_flag_o(zero_flag_o),
    .half_byte_borrow_flag_o(half_byte_borrow_flag_o), .sign_wrap_flag_o(sign_wrap_flag_o),
    .signed_chain_flag_o(signed_chain_flag_o), .chained_null_flag_o(chained_null_flag_o),
    .op_done_o(op_done_o), .op_illegal_o(op_illegal_o));

// ==== rrsb_alu_pkg.sv ====
package rrsb_alu_pkg;

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        rotate_mem_right = 3'h0,
        rotate_right_to_wreg = 3'h1,
        rotate_mem_right_thru_borrow_bit = 3'h2,
        rotate_right_thru_borrow_bit_to_wreg = 3'h3,
        subtract_borrow_to_wreg = 3'h4,
        subtract_borrow_to_mem = 3'h5
    } alu_op_t;

    localparam int unsigned DATA_W = 8;
    localparam int unsigned OP_W = 3;

    // ------------------------------------------------------------
    // status flag vector layout
    // ------------------------------------------------------------
    localparam int unsigned FLAG_W = 6;
    localparam int unsigned FLAG_CARRY_POS = 0;
    localparam int unsigned FLAG_ZERO_POS = 1;
    localparam int unsigned FLAG_HALF_POS = 2;
    localparam int unsigned FLAG_WRAP_POS = 3;
    localparam int unsigned FLAG_SCHAIN_POS = 4;
    localparam int unsigned FLAG_CNULL_POS = 5;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] WREG_RESET = 8'h00;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [7:0] MEM_DATA_RESET = 8'h00;

    // highest legal operation code
    localparam logic [2:0] OP_LAST = 3'h5;

endpackage : rrsb_alu_pkg

// ==== sub_borrow_unit.sv ====
`timescale 1ns/10ps

module sub_borrow_unit (
    // operands
    input wire logic [7:0] minuend_i,
    input wire logic [7:0] subtrahend_i,
    input wire logic carry_in_i,
    input wire logic chained_null_in_i,
    // results
    output logic [7:0] diff_o,
    output logic carry_o,
    output logic zero_o,
    output logic half_byte_borrow_flag_o,
    output logic sign_wrap_flag_o,
    output logic signed_chain_flag_o,
    output logic chained_null_flag_o
);
    import rrsb_alu_pkg::*;

    // ------------------------------------------------------------
    // subtraction with incoming borrow
    // ------------------------------------------------------------
    logic borrow_in;
    logic [8:0] full_diff;
    logic [4:0] nib_diff;

    // inverted carry acts as the incoming borrow
    assign borrow_in = ~carry_in_i;
    assign full_diff = {1'b0, minuend_i} - {1'b0, subtrahend_i} - {8'h00, borrow_in};
    assign nib_diff = {1'b0, minuend_i[3:0]} - {1'b0, subtrahend_i[3:0]} - {4'h0, borrow_in};

    // ------------------------------------------------------------
    // result and flags
    // ------------------------------------------------------------
    assign diff_o = full_diff[7:0];
    // carry is 1 when no borrow, 0 when the true result is negative
    assign carry_o = ~full_diff[8];
    assign zero_o = (full_diff[7:0] == 8'h00);
    // low nibble borrow, same polarity as carry
    assign half_byte_borrow_flag_o = ~nib_diff[4];
    // signed overflow: operand signs differ and result sign left the minuend's
    assign sign_wrap_flag_o = (minuend_i[7] ^ subtrahend_i[7]) & (full_diff[7] ^ minuend_i[7]);
    // true sign of the signed result, corrected by overflow
    assign signed_chain_flag_o = full_diff[7] ^ sign_wrap_flag_o;
    // zero across a multi-byte chain: this byte zero and all earlier ones zero
    assign chained_null_flag_o = zero_o & chained_null_in_i;

endmodule : sub_borrow_unit
